//--- rtl/tbg_regs.vh
// Purpose: Constants for the terminal board glue logic
// Assumes: 16-bit processor addresses, 40 MHz clock
// Notes:   Ranges are inclusive byte addresses
// Behaviour
// - Select program PROM at 0000-07FF
// - Select scratch RAM at 1000-13FF
// - Select screen memory at 2000-27FF, dual-ported
// - Display controller reads, processor reads and writes
// - Access to 3000 pulses main board reset
// - Select companion RAM at 4000-40FF
// - Port registers 4800-4803, timer 4804-4805
// - Serial link 5000-5001, display controller 7000-7001
// - Bell output selected at 6000
// - Rank five interrupt sources, vertical sync highest
// - Data strobe latches eight keyboard bits
// - Latched byte raises interrupt and ready flag
// - Send enable high; keyboard sends only then
// - Utility port: same strobe-latched input
// - Execution starts from PROM after power up
// - Board supplies serial clock to main board
`ifndef TBG_REGS_VH
`define TBG_REGS_VH
`define TBG_PROM_LO    16'h0000
`define TBG_PROM_HI    16'h07FF
`define TBG_SRAM_LO    16'h1000
`define TBG_SRAM_HI    16'h13FF
`define TBG_SMEM_LO    16'h2000
`define TBG_SMEM_HI    16'h27FF
`define TBG_RST_ADDR   16'h3000
`define TBG_CRAM_LO    16'h4000
`define TBG_CRAM_HI    16'h40FF
`define TBG_PORT_LO    16'h4800
`define TBG_PORT_HI    16'h4803
`define TBG_TMR_LO     16'h4804
`define TBG_TMR_HI     16'h4805
`define TBG_SER_LO     16'h5000
`define TBG_SER_HI     16'h5001
`define TBG_BELL_ADDR  16'h6000
`define TBG_DISP_LO    16'h7000
`define TBG_DISP_HI    16'h7001
`define TBG_SMEM_AW    11
`define TBG_RST_CYC    16'h0028
`define TBG_BELL_CYC   16'h0FA0
`define TBG_SCLK_DIV   8'h08
`endif

//--- rtl/tbg_glue.v
// Purpose: Address decode, interrupt ranking, parallel ports, screen memory
// Assumes: Inputs synchronous to clk_i; strobes active high, one per byte
// Notes:   Port bytes pass a two-entry buffer each
//          Reset and bell pulses restart on a new access
//          Serial clock runs free from reset release
`timescale 1ns/100ps
`include "tbg_regs.vh"

// ==========================================================
// Two-entry byte buffer
module tbg_buf2 (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire       in_valid_i,
  output wire       in_ready_o,
  input  wire [7:0] in_data_i,
  output wire       out_valid_o,
  input  wire       out_ready_i,
  output wire [7:0] out_data_o
);
  reg [7:0] mem_q [0:1];
  reg       wp_q;
  reg       rp_q;
  reg [1:0] cnt_q;
  wire      push = in_valid_i && (cnt_q != 2'd2);
  wire      pop  = out_ready_i && (cnt_q != 2'd0);
  assign in_ready_o  = (cnt_q != 2'd2);
  assign out_valid_o = (cnt_q != 2'd0);
  assign out_data_o  = mem_q[rp_q];

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'd0;
      mem_q[0] <= 8'h00;
      mem_q[1] <= 8'h00;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data_i;
        wp_q        <= ~wp_q;
      end
      if (pop)
        rp_q <= ~rp_q;
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
endmodule // tbg_buf2

// ==========================================================
// Retriggerable pulse stretcher
module tbg_pulse (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire        trig_i,
  input  wire [15:0] len_i,
  output reg         pulse_o
);
  localparam [1:0] ST_IDLE = 2'h1;
  localparam [1:0] ST_HOLD = 2'h2;
  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg [15:0] cnt_q;
  reg [15:0] cnt_d;

  always @* begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      ST_IDLE: begin
        if (trig_i) begin
          state_d = ST_HOLD;
          cnt_d   = len_i;
        end
      end
      ST_HOLD: begin
        if (trig_i) begin
          cnt_d = len_i;
        end else if (cnt_q > 16'h0001) begin
          cnt_d = cnt_q - 16'h0001;
        end else begin
          state_d = ST_IDLE;
          cnt_d   = 16'h0000;
        end
      end
      default: begin
        state_d = ST_IDLE;
        cnt_d   = 16'h0000;
      end
    endcase
  end

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ST_IDLE;
      cnt_q   <= 16'h0000;
      pulse_o <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      pulse_o <= state_d[1];
    end
  end
endmodule // tbg_pulse

// ==========================================================
// Free-running serial clock divider
module tbg_sclk_div (
  input  wire       clk_i,
  input  wire       rst_i,
  input  wire [7:0] half_i,
  output reg        sclk_o
);
  reg [7:0] div_q;

  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_q  <= 8'h00;
      sclk_o <= 1'b0;
    end else if (div_q == half_i - 8'h01) begin
      div_q  <= 8'h00;
      sclk_o <= ~sclk_o;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end
endmodule // tbg_sclk_div

// ==========================================================
// Glue top
module tbg_glue (
  input  wire        clk_i,
  input  wire        rst_i,
  input  wire [15:0] cpu_addr_i,
  input  wire        cpu_rd_i,
  input  wire        cpu_wr_i,
  input  wire [7:0]  cpu_wdata_i,
  output reg  [7:0]  smem_rdata_o,
  output wire        sel_prom_o,
  output wire        sel_sram_o,
  output wire        sel_smem_o,
  output wire        sel_cram_o,
  output wire        sel_port_o,
  output wire        sel_timer_o,
  output wire        sel_serial_o,
  output wire        sel_disp_o,
  output reg         host_reset_o,
  output reg         bell_o,
  output reg         host_sclk_o,
  input  wire [10:0] disp_addr_i,
  output reg  [7:0]  disp_char_o,
  input  wire        vsync_i,
  input  wire        host_receive_ready_i,
  input  wire        host_transmit_ready_i,
  output wire        irq_trap_o,
  output wire        irq_level_high_o,
  output wire        irq_level_mid_o,
  output wire        irq_level_low_o,
  output wire        general_irq_request_o,
  input  wire        keyboard_data_strobe_i,
  input  wire [7:0]  keyboard_data_i,
  output wire        keyboard_send_enable_o,
  input  wire        utility_data_strobe_i,
  input  wire [7:0]  utility_data_i,
  output wire        utility_send_enable_o,
  input  wire [1:0]  port_take_i,
  output wire [1:0]  port_ready_o,
  output wire [15:0] port_data_o
);
  // ==========================================================
  // Address decode
  function in_rng;
    input [15:0] a;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_rng = (a >= lo) && (a <= hi);
    end
  endfunction

  wire acc = cpu_rd_i || cpu_wr_i;
  localparam [127:0] RNG_LO = {`TBG_DISP_LO, `TBG_SER_LO, `TBG_TMR_LO, `TBG_PORT_LO,
                               `TBG_CRAM_LO, `TBG_SMEM_LO, `TBG_SRAM_LO, `TBG_PROM_LO};
  localparam [127:0] RNG_HI = {`TBG_DISP_HI, `TBG_SER_HI, `TBG_TMR_HI, `TBG_PORT_HI,
                               `TBG_CRAM_HI, `TBG_SMEM_HI, `TBG_SRAM_HI, `TBG_PROM_HI};
  wire [7:0] sel_w;
  genvar r;

  generate
    for (r = 0; r < 8; r = r + 1) begin : g_rng
      assign sel_w[r] = acc && in_rng(cpu_addr_i, RNG_LO[16*r+15:16*r], RNG_HI[16*r+15:16*r]);
    end
  endgenerate

  assign sel_prom_o   = sel_w[0];
  assign sel_sram_o   = sel_w[1];
  assign sel_smem_o   = sel_w[2];
  assign sel_cram_o   = sel_w[3];
  assign sel_port_o   = sel_w[4];
  assign sel_timer_o  = sel_w[5];
  assign sel_serial_o = sel_w[6];
  assign sel_disp_o   = sel_w[7];
  wire hit_rst  = acc && (cpu_addr_i == `TBG_RST_ADDR);
  wire hit_bell = acc && (cpu_addr_i == `TBG_BELL_ADDR);

  // ==========================================================
  // Screen memory, processor and display ports
  reg [7:0] smem_q [0:2047];
  always @(posedge clk_i) begin
    if (sel_smem_o && cpu_wr_i)
      smem_q[cpu_addr_i[`TBG_SMEM_AW-1:0]] <= cpu_wdata_i;
  end
  always @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      smem_rdata_o <= 8'h00;
      disp_char_o  <= 8'h00;
    end else begin
      smem_rdata_o <= smem_q[cpu_addr_i[`TBG_SMEM_AW-1:0]];
      disp_char_o  <= smem_q[disp_addr_i];
    end
  end

  // ==========================================================
  // Reset pulse, bell, serial clock
  tbg_pulse u_rst_pulse (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .trig_i  (hit_rst),
    .len_i   (`TBG_RST_CYC),
    .pulse_o (host_reset_o)
  );
  tbg_pulse u_bell_pulse (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .trig_i  (hit_bell),
    .len_i   (`TBG_BELL_CYC),
    .pulse_o (bell_o)
  );
  tbg_sclk_div u_sclk_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .half_i (`TBG_SCLK_DIV),
    .sclk_o (host_sclk_o)
  );

  // ==========================================================
  // Parallel input ports
  wire [1:0]  stb = {utility_data_strobe_i, keyboard_data_strobe_i};
  wire [15:0] din = {utility_data_i, keyboard_data_i};
  wire [1:0]  in_rdy;
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_port
      tbg_buf2 u_buf (
        .clk_i       (clk_i),
        .rst_i       (rst_i),
        .in_valid_i  (stb[g]),
        .in_ready_o  (in_rdy[g]),
        .in_data_i   (din[8*g+7:8*g]),
        .out_valid_o (port_ready_o[g]),
        .out_ready_i (port_take_i[g]),
        .out_data_o  (port_data_o[8*g+7:8*g])
      );
    end
  endgenerate
  assign keyboard_send_enable_o = in_rdy[0];
  assign utility_send_enable_o  = in_rdy[1];

  // ==========================================================
  // Interrupt ranking, one line active at a time
  function [4:0] irq_rank;
    input vs;
    input rx;
    input util;
    input kbd;
    input tx;
    begin
      if (vs)
        irq_rank = 5'h10;
      else if (rx)
        irq_rank = 5'h08;
      else if (util)
        irq_rank = 5'h04;
      else if (kbd)
        irq_rank = 5'h02;
      else if (tx)
        irq_rank = 5'h01;
      else
        irq_rank = 5'h00;
    end
  endfunction

  wire [4:0] irq_vec = irq_rank(vsync_i, host_receive_ready_i, port_ready_o[1],
                                port_ready_o[0], host_transmit_ready_i);
  assign irq_trap_o            = irq_vec[4];
  assign irq_level_high_o      = irq_vec[3];
  assign irq_level_mid_o       = irq_vec[2];
  assign irq_level_low_o       = irq_vec[1];
  assign general_irq_request_o = irq_vec[0];
endmodule // tbg_glue

//--- sim/tbg_glue_sva.sv
// Purpose: Assertions on decode, pulses, ranking, port latch
// Assumes: Bound to tbg_glue
// Notes:   Pulses checked over their first 8 cycles
`timescale 1ns/100ps
module tbg_glue_sva (
  input wire        clk_i, rst_i, cpu_rd_i, cpu_wr_i, host_reset_o, bell_o, vsync_i,
  input wire        sel_prom_o, sel_sram_o, sel_smem_o, sel_cram_o, sel_port_o,
  input wire        sel_timer_o, sel_serial_o, sel_disp_o, irq_trap_o, irq_level_high_o,
  input wire        irq_level_mid_o, irq_level_low_o,
  input wire        host_receive_ready_i, keyboard_data_strobe_i, keyboard_send_enable_o,
  input wire [15:0] cpu_addr_i,
  input wire [1:0]  port_ready_o
);
  // ========================================
  // Checks
  wire acc = cpu_rd_i | cpu_wr_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  prom_sel_a: assert property (sel_prom_o == (acc && cpu_addr_i < 16'h0800))
    else $error("prom select wrong");
  sram_sel_a: assert property (sel_sram_o == (acc && cpu_addr_i[15:10] == 6'h04))
    else $error("ram select wrong");
  smem_sel_a: assert property (sel_smem_o == (acc && cpu_addr_i[15:11] == 5'h04))
    else $error("screen select wrong");
  one_sel_a: assert property ($onehot0({sel_prom_o, sel_sram_o, sel_smem_o,
    sel_cram_o, sel_port_o, sel_timer_o, sel_serial_o, sel_disp_o}))
    else $error("two selects high");
  reset_pulse_a: assert property (acc && cpu_addr_i == 16'h3000 |=> host_reset_o[*8])
    else $error("reset pulse missing");
  bell_pulse_a: assert property (acc && cpu_addr_i == 16'h6000 |=> bell_o[*8])
    else $error("bell missing");
  trap_rank_a: assert property (vsync_i |-> irq_trap_o && !irq_level_high_o)
    else $error("trap not on top");
  high_rank_a: assert property (host_receive_ready_i && !vsync_i |-> irq_level_high_o)
    else $error("receive irq missing");
  kbd_latch_a: assert property (keyboard_data_strobe_i && keyboard_send_enable_o
    |=> port_ready_o[0])
    else $error("key byte not ready");
  mid_rank_a: assert property (port_ready_o[1] && !vsync_i && !host_receive_ready_i
    |-> irq_level_mid_o && !irq_level_low_o)
    else $error("utility irq rank wrong");
  low_rank_a: assert property (port_ready_o == 2'b01 && !vsync_i && !host_receive_ready_i
    |-> irq_level_low_o)
    else $error("key irq missing");
endmodule // tbg_glue_sva
bind tbg_glue tbg_glue_sva u_sva (.*);

//--- sim/tbg_kbd_model.sv
// Purpose: Keyboard or utility device on a strobed port
// Assumes: Strobe one cycle, never two in a row
// Notes:   Data wanders while no byte is offered
`timescale 1ns/100ps
module tbg_kbd_model (
  input  wire       clk_i,
  input  wire       en_i,
  input  wire       req_i,
  input  wire [7:0] byte_i,
  output reg        stb_o = 1'b0,
  output reg  [7:0] data_o = 8'h00
);
  always @(posedge clk_i) begin
    stb_o <= req_i & en_i & ~stb_o;
    data_o <= (req_i & en_i & ~stb_o) ? byte_i : ~data_o;
  end
endmodule // tbg_kbd_model

//--- sim/tbg_glue_tb.sv
// Purpose: Self-checking bench for tbg_glue
// Assumes: 40 MHz clock, reset 6 cycles
// Notes:   Port bytes checked through queues
`timescale 1ns/100ps
module tbg_glue_tb;
  reg         clk_i = 1'b0, rst_i = 1'b1, cpu_rd_i = 1'b0, cpu_wr_i = 1'b0, vsync_i = 1'b0;
  reg         host_receive_ready_i = 1'b0, host_transmit_ready_i = 1'b0;
  reg  [15:0] cpu_addr_i = 16'h0000, byts = 16'h0000, a;
  reg  [7:0]  cpu_wdata_i = 8'h00, kq[$], uq[$];
  reg  [10:0] disp_addr_i = 11'h000;
  reg  [1:0]  port_take_i = 2'b00, req = 2'b00;
  reg  [31:0] rb;
  reg  [15:0] lo[8] = '{16'h0000, 16'h1000, 16'h2000, 16'h4000, 16'h4800, 16'h4804, 16'h5000,
                       16'h7000};
  reg  [15:0] hi[8] = '{16'h07FF, 16'h13FF, 16'h27FF, 16'h40FF, 16'h4803, 16'h4805, 16'h5001,
                       16'h7001};
  wire [7:0]  smem_rdata_o, disp_char_o, keyboard_data_i, utility_data_i;
  wire [15:0] port_data_o;
  wire [1:0]  port_ready_o;
  wire        sel_prom_o, sel_sram_o, sel_smem_o, sel_cram_o, sel_port_o, sel_timer_o;
  wire        sel_serial_o, sel_disp_o, host_reset_o, bell_o, host_sclk_o, irq_trap_o;
  wire        irq_level_high_o, irq_level_mid_o, irq_level_low_o, general_irq_request_o;
  wire        keyboard_data_strobe_i, keyboard_send_enable_o, utility_data_strobe_i;
  wire        utility_send_enable_o;
  wire [7:0]  sels = {sel_disp_o, sel_serial_o, sel_timer_o, sel_port_o, sel_cram_o,
                      sel_smem_o, sel_sram_o, sel_prom_o};
  wire [4:0]  irqs = {irq_trap_o, irq_level_high_o, irq_level_mid_o, irq_level_low_o,
                      general_irq_request_o};
  int         s, mismatches = 0, comparisons = 0;
  tbg_glue u_tbg_glue (.*);
  tbg_kbd_model u_kbd (.clk_i(clk_i), .en_i(keyboard_send_enable_o), .req_i(req[0]),
    .byte_i(byts[7:0]), .stb_o(keyboard_data_strobe_i), .data_o(keyboard_data_i));
  tbg_kbd_model u_util (.clk_i(clk_i), .en_i(utility_send_enable_o), .req_i(req[1]),
    .byte_i(byts[15:8]), .stb_o(utility_data_strobe_i), .data_o(utility_data_i));
  always #12.5 clk_i = ~clk_i;
  task chk(input string n, input [15:0] e, input [15:0] g);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask
  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ========================================
  // Port byte scoreboard
  always @(posedge clk_i) begin
    if (keyboard_data_strobe_i & keyboard_send_enable_o) kq.push_back(keyboard_data_i);
    if (utility_data_strobe_i & utility_send_enable_o) uq.push_back(utility_data_i);
    if (port_ready_o[0] & port_take_i[0]) chk("kbd", kq.pop_front(), port_data_o[7:0]);
    if (port_ready_o[1] & port_take_i[1]) chk("util", uq.pop_front(), port_data_o[15:8]);
  end
  initial begin
    #250000;
    mismatches++;
    test_done;
  end
  // ========================================
  // Tests
  initial begin
    void'($urandom(32'h584a_b14e));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i) cpu_rd_i <= 1'b1;
    for (s = 0; s < 32; s++) begin
      a = s[1] ? hi[s[4:2]] + s[0] : lo[s[4:2]] - 16'(!s[0]);
      @(posedge clk_i) cpu_addr_i <= a;
      @(negedge clk_i);
      for (int j = 0; j < 8; j++) rb[j] = a >= lo[j] && a <= hi[j];
      chk("sel", 16'(rb[7:0]), 16'(sels));
    end
    $display("test decode done");
    @(posedge clk_i) cpu_addr_i <= 16'h3000;
    @(posedge clk_i) cpu_addr_i <= 16'h6000;
    @(posedge clk_i) cpu_rd_i <= 1'b0;
    repeat (30) @(negedge clk_i);
    chk("reset", 16'h0001, 16'(host_reset_o));
    chk("bell", 16'h0001, 16'(bell_o));
    repeat (20) @(negedge clk_i);
    chk("reset end", 16'h0000, 16'(host_reset_o));
    repeat (4000) @(negedge clk_i);
    chk("bell end", 16'h0000, 16'(bell_o));
    $display("test pulses done");
    for (s = 0; s < 8; s++) begin
      @(posedge clk_i) {vsync_i, host_receive_ready_i, host_transmit_ready_i} <= s[2:0];
      @(negedge clk_i);
      chk("irq", 16'({s[2], s[1] & ~s[2], 2'b00, s[0] & ~s[1] & ~s[2]}), 16'(irqs));
    end
    @(posedge clk_i) {vsync_i, host_receive_ready_i, host_transmit_ready_i} <= 3'b000;
    $display("test irq done");
    @(negedge host_sclk_o);
    s = 0;
    @(negedge clk_i);
    while (!host_sclk_o) begin
      s++;
      @(negedge clk_i);
    end
    chk("sclk", 16'h0008, 16'(s));
    $display("test sclk done");
    @(posedge clk_i) begin
      cpu_addr_i <= 16'h2123;
      cpu_wdata_i <= 8'h5a;
      cpu_wr_i <= 1'b1;
    end
    @(posedge clk_i) begin
      cpu_wr_i <= 1'b0;
      disp_addr_i <= 11'h123;
    end
    @(posedge clk_i);
    @(negedge clk_i) chk("smem", 16'h5a5a, {smem_rdata_o, disp_char_o});
    for (s = 0; s < 400; s++) begin
      rb = $urandom;
      @(posedge clk_i) begin
        req <= rb[1:0];
        byts <= rb[31:16];
        port_take_i <= (s > 300) ? 2'b11 : rb[3:2] & rb[5:4];
      end
    end
    @(posedge clk_i) req <= 2'b00;
    repeat (8) @(negedge clk_i);
    chk("drain", 16'h0000, 16'(kq.size() + uq.size()));
    $display("test ports done");
    test_done;
  end
endmodule // tbg_glue_tb
